// ==== sep_core.sv ====
// soft error parity protection: cache, translation buffer and branch
// target parity, uncorrectable memory bus errors, halt, apb registers
// assumes all inputs except rst_n_in synchronous to clk_sys_in
//
// Notes on behaviour
// [RL1] with fault tolerance on, detect internal ram errors and react to bus errors
// [RL2] caches check stored parity on every hit
// [RL3] cache parity mismatch invalidates the line for refetch
// [RL4] cache writes store tag bit, one icache data bit, dcache bit per word
// [RL5] fault tolerance on forces data cache write-through
// [RL6] translation parity mismatch raises translation miss exception
// [RL7] translation entry write stores one parity bit
// [RL8] translation entry read checks parity, clears valid bit on mismatch
// [RL9] branch target parity mismatch drops the prediction
// [RL10] branch target write stores one parity bit
// [RL11] memory controller reports its ram errors on bus error lines
// [RL12] exceptions enabled: uncorrectable error raises matching bus exception
// [RL13] bus exception during exception halts core and raises error output
// [RL14] even parity over covered bits; error output held until reset
`timescale 1ns/1ps
module sep_core
  import sep_pkg::*;
(
  input  wire logic            clk_sys_in,
  input  wire logic            rst_n_in,
  input  wire logic            clk_en_in,
  input  wire logic            psel_in,
  input  wire logic            penable_in,
  input  wire logic            pwrite_in,
  input  wire logic [AW-1:0]   paddr_in,
  input  wire logic [DW-1:0]   pwdata_in,
  output logic      [DW-1:0]   prdata_out,
  output logic                 pready_out,
  output logic                 pslverr_out,
  input  wire logic            cache_wr_in,
  input  wire logic            cache_is_d_in,
  input  wire sep_line_s       cache_line_in,
  output sep_par_s             cache_par_out,
  input  wire logic            cache_hit_in,
  input  wire logic            cache_hit_is_d_in,
  input  wire sep_line_s       cache_hit_line_in,
  input  wire sep_par_s        cache_hit_par_in,
  output logic                 cache_inval_out,
  output logic                 write_through_out,
  input  wire logic            wb_request_in,
  input  wire logic            tlb_wr_in,
  input  wire sep_tlb_s        tlb_wr_entry_in,
  output logic                 tlb_par_out,
  input  wire logic            tlb_xlat_in,
  input  wire sep_tlb_s        tlb_xlat_entry_in,
  input  wire logic            tlb_xlat_par_in,
  output logic                 tlb_miss_exc_out,
  input  wire logic            tlb_rd_in,
  input  wire sep_tlb_s        tlb_rd_entry_in,
  input  wire logic            tlb_rd_par_in,
  output sep_tlb_s             tlb_rd_entry_out,
  input  wire logic            btc_wr_in,
  input  wire logic [DW-1:0]   btc_wr_addr_in,
  output logic                 btc_par_out,
  input  wire logic            btc_lk_in,
  input  wire logic [DW-1:0]   btc_lk_addr_in,
  input  wire logic            btc_lk_par_in,
  output logic                 btc_pred_valid_out,
  output logic      [DW-1:0]   btc_pred_addr_out,
  input  wire logic            ue_ibus_in,
  input  wire logic            ue_dbus_in,
  input  wire logic            exception_enable_bit_in,
  input  wire logic            exc_in_progress_in,
  output logic                 ibus_exc_out,
  output logic                 dbus_exc_out,
  output logic                 halted_error_out,
  output logic                 irq_out
);

  logic [1:0]        rst_sync_reg;
  logic              rst_n;
  logic              ft_reg;
  logic [ST_W-1:0]   stat_reg;
  logic [ST_W-1:0]   stat_next;
  logic [ST_W-1:0]   mask_reg;
  logic [ECNT_W-1:0] ecnt_reg;
  logic [ECNT_W-1:0] ecnt_next;
  sep_run_e          run_reg;
  sep_run_e          run_next;

  // sync copy only; ungated so reset still releases while frozen
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rst_sync_reg <= 2'h0;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  // apb decode
  wire              apb_acc  = psel_in & penable_in & ~pready_out;
  wire              apb_done = psel_in & penable_in & pready_out;
  wire              hit_ctrl = paddr_in == OFS_CTRL;
  wire              hit_stat = paddr_in == OFS_STAT;
  wire              hit_mask = paddr_in == OFS_MASK;
  wire              hit_ecnt = paddr_in == OFS_ECNT;
  wire              hit_any  = hit_ctrl | hit_stat | hit_mask | hit_ecnt;
  wire              apb_wr   = apb_done & pwrite_in & hit_any;
  wire [ST_W-1:0]   stat_clr = (apb_wr & hit_stat) ? pwdata_in[ST_W-1:0] : '0;
  wire [DW-1:0]     rd_mux   =
    hit_ctrl ? {{(DW-1){1'b0}}, ft_reg} :
    hit_stat ? {{(DW-ST_W){1'b0}}, stat_reg} :
    hit_mask ? {{(DW-ST_W){1'b0}}, mask_reg} :
    hit_ecnt ? {{(DW-ECNT_W){1'b0}}, ecnt_reg} : '0;

  // parity checks, all gated by fault tolerance
  wire       ft = ft_reg; // see [RL1]
  wire sep_par_s hit_par = sep_calc_par(cache_hit_line_in, cache_hit_is_d_in);
  wire [WORDS-1:0] dmis = hit_par.data_p ^ cache_hit_par_in.data_p;
  wire       cache_mis = ft & cache_hit_in & ((hit_par.tag_p ^ cache_hit_par_in.tag_p) |
                         (cache_hit_is_d_in ? |dmis : dmis[0])); // see [RL2]
  wire       xlat_mis  = ft & tlb_xlat_in &
                         ((^tlb_xlat_entry_in) ^ tlb_xlat_par_in); // see [RL6]
  wire       rd_mis    = ft & tlb_rd_in & ((^tlb_rd_entry_in) ^ tlb_rd_par_in);
  wire       btc_mis   = ft & btc_lk_in & ((^btc_lk_addr_in) ^ btc_lk_par_in);
  wire       run       = run_reg == RUN_ACTIVE;
  wire       ue_i      = ft & exception_enable_bit_in & ue_ibus_in & run; // see [RL12]
  wire       ue_d      = ft & exception_enable_bit_in & ue_dbus_in & run;
  wire       go_halt   = (ue_i | ue_d) & exc_in_progress_in; // see [RL13]
  wire       perr      = cache_mis | xlat_mis | rd_mis | btc_mis;
  wire [ST_W-1:0] stat_set = {go_halt, ue_d, ue_i, btc_mis, xlat_mis | rd_mis, cache_mis};

  // set wins over a write-one clear in the same cycle
  assign stat_next = (stat_reg & ~stat_clr) | stat_set;
  assign ecnt_next = (perr && ecnt_reg != ECNT_MAX) ? ecnt_reg + 1'b1 : ecnt_reg;

  always_comb
  begin
    run_next = run_reg;
    case (run_reg)
      RUN_ACTIVE: if (go_halt) run_next = RUN_HALTED;
      RUN_HALTED: run_next = RUN_HALTED; // see [RL14]
      default:    run_next = RUN_HALTED;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= '0;
    end
    else if (clk_en_in)
    begin
      pready_out  <= apb_acc;
      pslverr_out <= apb_acc & ~hit_any;
      prdata_out  <= apb_acc ? rd_mux : '0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ft_reg   <= CTRL_FT_RST;
      mask_reg <= MASK_RST;
      stat_reg <= '0;
      ecnt_reg <= '0;
      irq_out  <= 1'b0;
    end
    else if (clk_en_in)
    begin
      if (apb_wr & hit_ctrl)
        ft_reg <= pwdata_in[CTRL_FT_BIT];
      if (apb_wr & hit_mask)
        mask_reg <= pwdata_in[ST_W-1:0];
      if (apb_wr & hit_ecnt)
        ecnt_reg <= '0;
      else
        ecnt_reg <= ecnt_next;
      stat_reg <= stat_next;
      irq_out  <= |(stat_next & mask_reg);
    end
  end

  // cache and write policy
  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cache_par_out     <= '0;
      cache_inval_out   <= 1'b0;
      write_through_out <= 1'b1;
    end
    else if (clk_en_in)
    begin
      if (cache_wr_in)
        cache_par_out <= sep_calc_par(cache_line_in, cache_is_d_in); // see [RL4]
      cache_inval_out   <= cache_mis; // see [RL3]
      write_through_out <= ft | ~wb_request_in; // see [RL5]
    end
  end

  // translation buffer and branch target cache
  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tlb_par_out        <= 1'b0;
      tlb_miss_exc_out   <= 1'b0;
      tlb_rd_entry_out   <= '0;
      btc_par_out        <= 1'b0;
      btc_pred_valid_out <= 1'b0;
      btc_pred_addr_out  <= '0;
    end
    else if (clk_en_in)
    begin
      if (tlb_wr_in)
        tlb_par_out <= ^tlb_wr_entry_in; // see [RL7]
      tlb_miss_exc_out <= xlat_mis;
      if (tlb_rd_in)
      begin
        tlb_rd_entry_out <= tlb_rd_entry_in;
        if (rd_mis)
          tlb_rd_entry_out.hi[TLB_V_BIT] <= 1'b0; // see [RL8]
      end
      if (btc_wr_in)
        btc_par_out <= ^btc_wr_addr_in; // see [RL10]
      btc_pred_valid_out <= btc_lk_in & ~btc_mis; // see [RL9]
      btc_pred_addr_out  <= btc_lk_addr_in;
    end
  end

  // bus exceptions and halt
  always_ff @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run_reg          <= RUN_ACTIVE;
      ibus_exc_out     <= 1'b0;
      dbus_exc_out     <= 1'b0;
      halted_error_out <= 1'b0;
    end
    else if (clk_en_in)
    begin
      run_reg          <= run_next;
      ibus_exc_out     <= ue_i & ~exc_in_progress_in;
      dbus_exc_out     <= ue_d & ~exc_in_progress_in;
      halted_error_out <= run_next == RUN_HALTED; // see [RL13]
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n);

  property p_inval;
    clk_en_in && cache_hit_in && cache_mis |=> cache_inval_out;
  endproperty
  a_inval: assert property (p_inval) else $error("mismatch not invalidated"); // see [RL3]

  property p_clean;
    clk_en_in && ft_reg && cache_hit_in && !cache_mis |=> !cache_inval_out;
  endproperty
  a_clean: assert property (p_clean) else $error("clean hit invalidated"); // see [RL2]

  property p_cpar;
    clk_en_in && cache_wr_in |=>
      cache_par_out == sep_calc_par($past(cache_line_in), $past(cache_is_d_in));
  endproperty
  a_cpar: assert property (p_cpar) else $error("cache parity wrong"); // see [RL4]

  property p_wt;
    clk_en_in && ft_reg |=> write_through_out;
  endproperty
  a_wt: assert property (p_wt) else $error("write-back with protection"); // see [RL5]

  property p_miss;
    clk_en_in && ft_reg && tlb_xlat_in &&
      ((^tlb_xlat_entry_in) != tlb_xlat_par_in) |=> tlb_miss_exc_out;
  endproperty
  a_miss: assert property (p_miss) else $error("no translation miss"); // see [RL6]

  property p_tpar;
    clk_en_in && tlb_wr_in |=> tlb_par_out == ^$past(tlb_wr_entry_in);
  endproperty
  a_tpar: assert property (p_tpar) else $error("entry parity wrong"); // see [RL7]

  property p_tval;
    clk_en_in && rd_mis |=> !tlb_rd_entry_out.hi[TLB_V_BIT];
  endproperty
  a_tval: assert property (p_tval) else $error("bad entry still valid"); // see [RL8]

  property p_btc;
    clk_en_in && btc_mis |=> !btc_pred_valid_out;
  endproperty
  a_btc: assert property (p_btc) else $error("bad prediction used"); // see [RL9]

  property p_bpar;
    clk_en_in && btc_wr_in |=> btc_par_out == ^$past(btc_wr_addr_in);
  endproperty
  a_bpar: assert property (p_bpar) else $error("target parity wrong"); // see [RL10]

  property p_iexc;
    clk_en_in && ft_reg && exception_enable_bit_in && ue_ibus_in && run &&
      !exc_in_progress_in |=> ibus_exc_out && !halted_error_out;
  endproperty
  a_iexc: assert property (p_iexc) else $error("no bus exception"); // see [RL12]

  property p_halt;
    clk_en_in && go_halt |=> halted_error_out [*3];
  endproperty
  a_halt: assert property (p_halt) else $error("halt not held"); // see [RL13]

  property p_stick;
    halted_error_out |=> halted_error_out && !ibus_exc_out && !dbus_exc_out;
  endproperty
  a_stick: assert property (p_stick) else $error("error output dropped"); // see [RL14]

endmodule // sep_core

// ==== sep_pkg.sv ====
// constants, types and parity helpers for the soft error parity block
// assumes one clock domain; users import the whole package
package sep_pkg;
  localparam int TAG_W = 20;
  localparam int WORDS = 4;
  localparam int DW = 32;
  localparam int AW = 8;
  localparam logic [AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [AW-1:0] OFS_STAT = 8'h04;
  localparam logic [AW-1:0] OFS_MASK = 8'h08;
  localparam logic [AW-1:0] OFS_ECNT = 8'h0C;
  localparam int CTRL_FT_BIT = 0;
  localparam logic CTRL_FT_RST = 1'b1;
  localparam int ST_W = 6;
  localparam int ST_CACHE = 0;
  localparam int ST_TLB = 1;
  localparam int ST_BTC = 2;
  localparam int ST_IUE = 3;
  localparam int ST_DUE = 4;
  localparam int ST_HALT = 5;
  localparam logic [ST_W-1:0] MASK_RST = 6'h00;
  localparam int TLB_V_BIT = 6;
  localparam int ECNT_W = 16;
  localparam logic [ECNT_W-1:0] ECNT_MAX = 16'hFFFF;

  typedef enum logic {RUN_ACTIVE, RUN_HALTED} sep_run_e;

  typedef struct packed {
    logic [TAG_W-1:0]    tag;
    logic [WORDS*DW-1:0] data;
  } sep_line_s;

  typedef struct packed {
    logic             tag_p;
    logic [WORDS-1:0] data_p;
  } sep_par_s;

  typedef struct packed {
    logic [DW-1:0] hi;
    logic [DW-1:0] lo;
  } sep_tlb_s;

  // even parity: stored bit makes the covered bits plus itself even
  function automatic sep_par_s sep_calc_par(input sep_line_s l, input logic is_d);
    sep_par_s p;
    p.tag_p = ^l.tag;
    p.data_p = '0;
    if (is_d)
      for (int i = 0; i < WORDS; i++) p.data_p[i] = ^l.data[i*DW +: DW];
    else
      p.data_p[0] = ^l.data;
    return p;
  endfunction
endpackage

// ==== sep_mem_model.sv ====
// memory controller stand-in: flags uncorrectable ram errors
// assumes the bench requests each error, same clock as the core
`timescale 1ns/1ps
module sep_mem_model (
  input  wire logic clk_sys_in,
  input  wire logic rst_n_in,
  input  wire logic bad_i_in,
  input  wire logic bad_d_in,
  output logic      ue_ibus_out,
  output logic      ue_dbus_out
);
  // error lines idle low; an error lasts as long as its request is held
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      ue_ibus_out <= 1'h0;
      ue_dbus_out <= 1'h0;
    end
    else
    begin
      ue_ibus_out <= bad_i_in;
      ue_dbus_out <= bad_d_in;
    end
endmodule // sep_mem_model

// ==== soft_error_parity_protection_tb.sv ====
// bench for sep_core: parity events, apb registers, bus errors, halt
// assumes sep_pkg and sep_mem_model compiled first
`timescale 1ns/1ps
module soft_error_parity_protection_tb;
  import sep_pkg::*;
  logic clk_sys_in = 0, rst_n_in = 0, clk_en_in = 1, psel_in = 0, penable_in = 0;
  logic pwrite_in = 0, pready_out, pslverr_out, cache_wr_in = 0, cache_is_d_in = 0;
  logic cache_hit_in = 0, cache_hit_is_d_in = 0, cache_inval_out, write_through_out;
  logic wb_request_in = 0, tlb_wr_in = 0, tlb_par_out, tlb_xlat_in = 0;
  logic tlb_xlat_par_in = 0, tlb_miss_exc_out, tlb_rd_in = 0, tlb_rd_par_in = 0;
  logic btc_wr_in = 0, btc_par_out, btc_lk_in = 0, btc_lk_par_in = 0, btc_pred_valid_out;
  logic ue_ibus_in, ue_dbus_in, exception_enable_bit_in = 0, exc_in_progress_in = 0;
  logic ibus_exc_out, dbus_exc_out, halted_error_out, irq_out, bad_i = 0, bad_d = 0;
  logic [AW-1:0] paddr_in = '0;
  logic [DW-1:0] pwdata_in = '0, prdata_out, btc_wr_addr_in = '0, btc_lk_addr_in = '0;
  logic [DW-1:0] btc_pred_addr_out;
  sep_line_s     cache_line_in = '0, cache_hit_line_in = '0;
  sep_par_s      cache_par_out, cache_hit_par_in = '0;
  sep_tlb_s      tlb_wr_entry_in = '0, tlb_xlat_entry_in = '0, tlb_rd_entry_in = '0;
  sep_tlb_s      tlb_rd_entry_out;
  int            fail_count = 0, checks_done = 0;

  sep_core i_sep_core (.clk_sys_in, .rst_n_in, .clk_en_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
    .cache_wr_in, .cache_is_d_in, .cache_line_in, .cache_par_out, .cache_hit_in,
    .cache_hit_is_d_in, .cache_hit_line_in, .cache_hit_par_in, .cache_inval_out,
    .write_through_out, .wb_request_in, .tlb_wr_in, .tlb_wr_entry_in, .tlb_par_out,
    .tlb_xlat_in, .tlb_xlat_entry_in, .tlb_xlat_par_in, .tlb_miss_exc_out, .tlb_rd_in,
    .tlb_rd_entry_in, .tlb_rd_par_in, .tlb_rd_entry_out, .btc_wr_in, .btc_wr_addr_in,
    .btc_par_out, .btc_lk_in, .btc_lk_addr_in, .btc_lk_par_in, .btc_pred_valid_out,
    .btc_pred_addr_out, .ue_ibus_in, .ue_dbus_in, .exception_enable_bit_in,
    .exc_in_progress_in, .ibus_exc_out, .dbus_exc_out, .halted_error_out, .irq_out);
  sep_mem_model i_sep_mem_model (.clk_sys_in, .rst_n_in, .bad_i_in(bad_i),
    .bad_d_in(bad_d), .ue_ibus_out(ue_ibus_in), .ue_dbus_out(ue_dbus_in));

  initial
    forever #2.5 clk_sys_in = ~clk_sys_in;

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // request held until pready is sampled high; bounded wait
  task automatic apb(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] wd,
                     output logic [DW-1:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    {psel_in, pwrite_in, paddr_in, pwdata_in} <= {1'h1, w, a, wd};
    @(posedge clk_sys_in);
    penable_in <= 1'h1;
    do
    begin
      @(posedge clk_sys_in);
      n++;
    end
    while (pready_out !== 1'h1 && n < 20);
    rd = prdata_out;
    err = pslverr_out;
    {psel_in, penable_in} <= 2'h0;
    if (n >= 20)
    begin
      fail_count++;
      print_verdict;
    end
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    logic [DW-1:0] r;
    logic e;
    apb(1'h1, a, d, r, e);
    repeat (2) @(posedge clk_sys_in);
    #1;
  endtask

  // strobes stand one edge; answers land on that edge
  task automatic strobe_end;
    @(posedge clk_sys_in);
    {cache_wr_in, cache_hit_in, tlb_wr_in, tlb_xlat_in, tlb_rd_in, btc_wr_in, btc_lk_in} <= '0;
    #1;
  endtask

  task automatic hit(input logic d, input sep_line_s l, input sep_par_s p, input logic x);
    @(posedge clk_sys_in);
    {cache_hit_in, cache_hit_is_d_in, cache_hit_line_in, cache_hit_par_in} <= {1'h1, d, l, p};
    strobe_end;
    chk(32'(cache_inval_out), 32'(x));
  endtask

  // error from the controller reaches the core one edge after the request
  task automatic ue_evt(input logic i, input logic d);
    @(posedge clk_sys_in);
    {bad_i, bad_d} <= {i, d};
    @(posedge clk_sys_in);
    {bad_i, bad_d} <= 2'h0;
    @(posedge clk_sys_in);
    #1;
  endtask

  task automatic t_regs;
    logic [DW-1:0] r;
    logic e;
    chk(32'({write_through_out, halted_error_out}), 32'h2);
    apb(1'h0, OFS_CTRL, '0, r, e);
    chk(r, 32'h1);
    apb(1'h1, 8'h10, 32'hFFFF_FFFF, r, e);
    chk(32'(e), 32'h1);
    apb(1'h0, 8'h10, '0, r, e);
    chk({r[30:0], e}, 32'h1);
  endtask

  task automatic t_cache_irq;
    sep_line_s li, ld;
    logic [DW-1:0] r;
    logic e;
    li = '{tag: 20'h3, data: 128'h1};
    ld = '{tag: 20'h1, data: {32'h0, 32'h7, 32'h3, 32'h1}};
    @(posedge clk_sys_in);
    {cache_wr_in, cache_is_d_in, cache_line_in} <= {1'h1, 1'h0, li};
    strobe_end;
    chk(32'(cache_par_out), 32'h01);
    @(posedge clk_sys_in);
    {cache_wr_in, cache_is_d_in, cache_line_in} <= {1'h1, 1'h1, ld};
    strobe_end;
    chk(32'(cache_par_out), 32'h15);
    hit(1'h1, ld, 5'h15, 1'h0);
    hit(1'h1, ld, 5'h11, 1'h1);
    hit(1'h0, li, 5'h00, 1'h1);
    hit(1'h0, li, 5'h01, 1'h0);
    chk(32'(irq_out), 32'h0);
    apb(1'h0, OFS_STAT, '0, r, e);
    chk(32'(r[ST_CACHE]), 32'h1);
    wr(OFS_MASK, 32'h1);
    chk(32'(irq_out), 32'h1);
    wr(OFS_STAT, 32'h1);
    chk(32'(irq_out), 32'h0);
  endtask

  task automatic t_tlb_btc;
    logic [DW-1:0] r;
    logic e;
    @(posedge clk_sys_in);
    {tlb_wr_in, tlb_wr_entry_in} <= {1'h1, 64'h40_0000_0000};
    {btc_wr_in, btc_wr_addr_in} <= {1'h1, 32'h7};
    strobe_end;
    chk(32'({tlb_par_out, btc_par_out}), 32'h3);
    for (int p = 0; p < 2; p++)
    begin
      @(posedge clk_sys_in);
      {tlb_xlat_in, tlb_xlat_entry_in, tlb_xlat_par_in} <= {1'h1, 64'h40_0000_0000, p[0]};
      {tlb_rd_in, tlb_rd_entry_in, tlb_rd_par_in} <= {1'h1, 64'h40_0000_0000, p[0]};
      {btc_lk_in, btc_lk_addr_in, btc_lk_par_in} <= {1'h1, 32'h7, p[0]};
      strobe_end;
      chk(32'(tlb_miss_exc_out), 32'(!p[0]));
      chk(tlb_rd_entry_out.hi, p[0] ? 32'h40 : 32'h0);
      chk(32'(btc_pred_valid_out), 32'(p[0]));
    end
    chk(btc_pred_addr_out, 32'h7);
    // one cycle held three translation/target mismatches: counted once
    apb(1'h0, OFS_STAT, '0, r, e);
    chk(r, 32'h6);
    apb(1'h0, OFS_ECNT, '0, r, e);
    chk(r, 32'h3);
    wr(OFS_ECNT, 32'h0);
    apb(1'h0, OFS_ECNT, '0, r, e);
    chk(r, 32'h0);
  endtask

  task automatic t_ue_ft;
    @(posedge clk_sys_in);
    exception_enable_bit_in <= 1'h1;
    ue_evt(1'h1, 1'h0);
    chk(32'({ibus_exc_out, dbus_exc_out}), 32'h2);
    ue_evt(1'h1, 1'h1);
    chk(32'({ibus_exc_out, dbus_exc_out}), 32'h3);
    @(posedge clk_sys_in);
    exception_enable_bit_in <= 1'h0;
    ue_evt(1'h0, 1'h1);
    chk(32'(dbus_exc_out), 32'h0);
    @(posedge clk_sys_in);
    wb_request_in <= 1'h1;
    repeat (2) @(posedge clk_sys_in);
    #1 chk(32'(write_through_out), 32'h1);
    wr(OFS_CTRL, 32'h0);
    chk(32'(write_through_out), 32'h0);
    hit(1'h1, '{tag: 20'h1, data: 128'h0}, 5'h00, 1'h0);
    wr(OFS_CTRL, 32'h1);
    // frozen core must ignore a bad hit
    @(posedge clk_sys_in);
    clk_en_in <= 1'h0;
    hit(1'h1, '{tag: 20'h1, data: 128'h0}, 5'h00, 1'h0);
    @(posedge clk_sys_in);
    clk_en_in <= 1'h1;
  endtask

  task automatic t_halt;
    logic [DW-1:0] r;
    logic e;
    @(posedge clk_sys_in);
    exception_enable_bit_in <= 1'h1;
    exc_in_progress_in <= 1'h1;
    ue_evt(1'h1, 1'h0);
    chk(32'({halted_error_out, ibus_exc_out}), 32'h2);
    @(posedge clk_sys_in);
    exc_in_progress_in <= 1'h0;
    ue_evt(1'h0, 1'h1);
    chk(32'({halted_error_out, dbus_exc_out}), 32'h2);
    apb(1'h0, OFS_STAT, '0, r, e);
    chk(32'({r[ST_HALT], r[ST_IUE]}), 32'h3);
  endtask

  initial
  begin
    repeat (4) @(posedge clk_sys_in);
    rst_n_in <= 1'h1;
    repeat (3) @(posedge clk_sys_in);
    #1;
    t_regs;
    t_cache_irq;
    t_tlb_btc;
    t_ue_ft;
    t_halt;
    print_verdict;
  end
endmodule // soft_error_parity_protection_tb
